// *** core/uswc_defines.svh ***
/*
 constants for the suspend and remote-wakeup control: register offsets,
 field positions, reset values. assumes a 25 mhz clock and a word-aligned
 avalon-mm slave.
*/
`ifndef USWC_DEFINES_SVH
`define USWC_DEFINES_SVH
`define USWC_OFS_CTRL     4'h0
`define USWC_OFS_WKEN     4'h4
`define USWC_OFS_STAT     4'h8
`define USWC_OFS_IRQ_MSK  4'hC
`define USWC_OFS_PWR      5'h10
`define USWC_OFS_STATE    5'h14
`define USWC_DEPTH_LSB    0
`define USWC_SUSP_BIT     2
`define USWC_DEPTH_RST    2'h2
`define USWC_EV_GPIO      0
`define USWC_EV_MAGIC     1
`define USWC_EV_WAKE      2
`define USWC_EV_LINK      3
`define USWC_EV_WAKEUP    4
`define USWC_NUM_EV       5
`define USWC_GPIO_N       8
`define USWC_PORTS_N      3
`endif

// *** core/uswc_pkg.sv ***
/*
 types for the suspend and remote-wakeup control.
 assumes uswc_defines.svh supplies the numbers.
*/
package uswc_pkg;
   typedef enum logic [1:0] {
      USWC_SLEEP_SHALLOW      = 2'h0,
      USWC_SLEEP_INTERMEDIATE = 2'h1,
      USWC_SLEEP_DEEPEST      = 2'h2
   } uswc_depth_t;
   typedef enum {USWC_AWAKE, USWC_ASLEEP, USWC_WAKING} uswc_state_t;
   typedef struct packed {
      logic magic;
      logic wake;
      logic link;
   } uswc_net_ev_t;
endpackage

// *** core/uswc_top.sv ***
/*
 suspend and remote-wakeup control with avalon-mm register slave.
 assumes gpio and network event inputs come from other clock domains
 and are synchronised here; suspend request comes from the usb core on clk.
*/
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "uswc_defines.svh"
module uswc_top #(
   parameter int GPIO_N  = `USWC_GPIO_N,
   parameter int PORTS_N = `USWC_PORTS_N
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic [3:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 suspend_req,
   input  wire logic                 resume_req,
   input  wire logic [GPIO_N-1:0]    gpio_in,
   input  wire uswc_pkg::uswc_net_ev_t net_ev,
   input  wire logic [PORTS_N-1:0]   port_power_en,
   output logic                      remote_wakeup,
   output logic                      mac_clk_en,
   output logic                      suspended,
   output logic [PORTS_N-1:0]        port_phy_lowpwr,
   output logic                      irq
);
   localparam int NE = `USWC_NUM_EV;
   logic [1:0]         rst_sync_ff;
   logic               rst_n;
   logic [GPIO_N-1:0]  gpio_s1_ff, gpio_s2_ff, gpio_prev_ff;
   logic [2:0]         net_s1_ff, net_s2_ff, net_prev_ff;
   logic [1:0]         depth_ff;
   logic [GPIO_N-1:0]  gpio_en_ff;
   logic [2:0]         net_en_ff;
   logic [NE-1:0]      stat_ff, msk_ff;
   logic               ack_ff;
   logic [31:0]        rdata_ff;
   logic               mac_clk_en_ff, wake_ff;
   logic [PORTS_N-1:0] phy_lp_ff;
   uswc_pkg::uswc_state_t state_ff, nxt_state;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rst_sync_ff <= 2'h0;
      else       rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // two stages before any logic looks at external events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpio_s1_ff   <= '0;
         gpio_s2_ff   <= '0;
         gpio_prev_ff <= '0;
         net_s1_ff    <= 3'h0;
         net_s2_ff    <= 3'h0;
         net_prev_ff  <= 3'h0;
      end else begin
         gpio_s1_ff   <= gpio_in;
         gpio_s2_ff   <= gpio_s1_ff;
         gpio_prev_ff <= gpio_s2_ff;
         net_s1_ff    <= net_ev;
         net_s2_ff    <= net_s1_ff;
         net_prev_ff  <= net_s2_ff;
      end
   end

   // bus decode
   wire       acc      = (avs_read | avs_write) & ~ack_ff;
   wire [4:0] addr_b   = {1'b0, avs_address};
   wire       sel_ctrl = addr_b == {1'b0, `USWC_OFS_CTRL};
   wire       sel_wken = addr_b == {1'b0, `USWC_OFS_WKEN};
   wire       sel_stat = addr_b == {1'b0, `USWC_OFS_STAT};
   wire       sel_msk  = addr_b == {1'b0, `USWC_OFS_IRQ_MSK};
   // a write lands only on the edge where waitrequest is sampled low
   wire       wr       = avs_write & ack_ff;
   wire [1:0] wr_depth = avs_writedata[`USWC_DEPTH_LSB +: 2];
   wire       depth_ok = wr_depth != 2'h3;

   // depth gating of the three network events
   wire [2:0] net_rise   = net_s2_ff & ~net_prev_ff;
   wire       is_sh      = depth_ff == uswc_pkg::USWC_SLEEP_SHALLOW;
   wire       is_mid     = depth_ff == uswc_pkg::USWC_SLEEP_INTERMEDIATE;
   wire       asleep     = state_ff == uswc_pkg::USWC_ASLEEP;
   wire [2:0] depth_perm = {is_sh, is_sh, is_mid};
   wire [2:0] net_hit    = net_rise & net_en_ff & depth_perm;
   wire       gpio_hit   = |(gpio_s2_ff & ~gpio_prev_ff & gpio_en_ff);
   wire       wake_now   = asleep & (gpio_hit | (|net_hit));
   wire [NE-1:0] ev      = {wake_now, net_hit[0] & asleep,
                            net_hit[2] & asleep, net_hit[1] & asleep, gpio_hit & asleep};

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         uswc_pkg::USWC_AWAKE:  if (suspend_req) nxt_state = uswc_pkg::USWC_ASLEEP;
         uswc_pkg::USWC_ASLEEP: begin
            if (resume_req)    nxt_state = uswc_pkg::USWC_AWAKE;
            else if (wake_now) nxt_state = uswc_pkg::USWC_WAKING;
         end
         uswc_pkg::USWC_WAKING: if (resume_req) nxt_state = uswc_pkg::USWC_AWAKE;
         default: nxt_state = uswc_pkg::USWC_AWAKE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff      <= uswc_pkg::USWC_AWAKE;
         depth_ff      <= `USWC_DEPTH_RST;
         gpio_en_ff    <= '0;
         net_en_ff     <= 3'h0;
         msk_ff        <= '0;
         stat_ff       <= '0;
         mac_clk_en_ff <= 1'b1;
         wake_ff       <= 1'b0;
         phy_lp_ff     <= '1;
      end else begin
         state_ff <= nxt_state;
         if (wr && sel_ctrl && depth_ok) depth_ff <= wr_depth;
         if (wr && sel_wken) begin
            gpio_en_ff <= avs_writedata[8 +: GPIO_N];
            net_en_ff  <= avs_writedata[2:0];
         end
         if (wr && sel_msk) msk_ff <= avs_writedata[NE-1:0];
         // set beats write-one-to-clear in the same cycle
         stat_ff <= (stat_ff & ~((wr && sel_stat) ? avs_writedata[NE-1:0] : '0)) | ev;
         // shallow stops mac clock; deeper depths stop it too
         mac_clk_en_ff <= (nxt_state == uswc_pkg::USWC_AWAKE);
         wake_ff       <= (nxt_state == uswc_pkg::USWC_WAKING);
         phy_lp_ff     <= ~port_power_en;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= acc;
         case (addr_b)
            {1'b0, `USWC_OFS_CTRL}:    rdata_ff <= {30'h0000_0000, depth_ff};
            {1'b0, `USWC_OFS_WKEN}:    rdata_ff <= {16'h0000, gpio_en_ff, 5'h00, net_en_ff};
            {1'b0, `USWC_OFS_STAT}:    rdata_ff <= {27'h000_0000, stat_ff};
            {1'b0, `USWC_OFS_IRQ_MSK}: rdata_ff <= {27'h000_0000, msk_ff};
            default:                   rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata    = rdata_ff;
   assign remote_wakeup   = wake_ff;
   assign mac_clk_en      = mac_clk_en_ff;
   assign suspended       = ~mac_clk_en_ff;
   assign port_phy_lowpwr = phy_lp_ff;
   assign irq             = |(stat_ff & msk_ff);

   a_deep_no_net: assert property (@(posedge clk) disable iff (!rst_n)
      (depth_ff == uswc_pkg::USWC_SLEEP_DEEPEST) |-> net_hit == 3'h0) else $error("net wake in deepest");
   a_mid_only_link: assert property (@(posedge clk) disable iff (!rst_n)
      is_mid |-> net_hit[2:1] == 2'h0) else $error("frame wake in intermediate");
   a_shallow_frames: assert property (@(posedge clk) disable iff (!rst_n)
      is_sh |-> net_hit[0] == 1'b0) else $error("link wake in shallow");
   a_wake_when_asleep: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(remote_wakeup) |-> $past(state_ff) == uswc_pkg::USWC_ASLEEP) else $error("wake not from sleep");
   a_gpio_wakes: assert property (@(posedge clk) disable iff (!rst_n)
      (asleep && gpio_hit && !resume_req) |=> remote_wakeup) else $error("gpio wake missed");
   a_mac_clk_off: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == uswc_pkg::USWC_AWAKE && suspend_req) |=> !mac_clk_en) else $error("mac clock kept");
   a_phy_lowpwr: assert property (@(posedge clk) disable iff (!rst_n)
      !port_power_en[0] |=> port_phy_lowpwr[0]) else $error("phy not low power");
   a_en_gates: assert property (@(posedge clk) disable iff (!rst_n)
      (net_en_ff == 3'h0) |-> net_hit == 3'h0) else $error("disabled event passed");
   a_reset_depth: assert property (@(posedge clk)
      $rose(rst_n) |-> depth_ff == `USWC_DEPTH_RST) else $error("reset depth wrong");
   c_gpio_wake: cover property (@(posedge clk) disable iff (!rst_n) asleep && gpio_hit);
   c_magic_wake: cover property (@(posedge clk) disable iff (!rst_n) asleep && net_hit[2]);
   c_link_wake: cover property (@(posedge clk) disable iff (!rst_n) asleep && net_hit[0]);
endmodule // uswc_top

// *** verif/tb.sv ***
/*
 bench for the suspend and remote-wakeup control: table of wake cases, then
 interrupt, unmapped, reset and port power checks. assumes the host model.
*/
`timescale 1ns/1ps
`include "uswc_defines.svh"
module tb;
   typedef struct packed {logic sl; logic [1:0] d; logic [2:0] n; logic [7:0] g; logic e;} uswc_row_t;
   logic                   clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, seen;
   logic                   go_sleep = 1'b0, go_wake = 1'b0, slow = 1'b0, suspend_req, resume_req;
   logic                   avs_waitrequest, remote_wakeup, mac_clk_en, suspended, irq;
   logic [3:0]             avs_address = 4'h0;
   logic [31:0]            avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic [7:0]             gpio_in = 8'h00;
   logic [2:0]             port_power_en = 3'h0, port_phy_lowpwr;
   uswc_pkg::uswc_net_ev_t net_ev = '0;
   int                     err_total = 0, checks = 0, cyc = 0;
   uswc_row_t              rows [10] = '{
      '{1, 0, 4, 0, 1}, '{1, 0, 2, 0, 1}, '{1, 0, 1, 0, 0},
      '{1, 1, 1, 0, 1}, '{1, 1, 4, 0, 0},
      '{1, 2, 4, 0, 0}, '{1, 2, 1, 0, 0},
      '{1, 2, 0, 8'h80, 1}, '{1, 1, 0, 8'h01, 1},
      '{0, 0, 4, 0, 0}};
   uswc_top dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .suspend_req, .resume_req, .gpio_in, .net_ev, .port_power_en,
      .remote_wakeup, .mac_clk_en, .suspended, .port_phy_lowpwr, .irq);
   uswc_host_model host (.clk, .rstn, .remote_wakeup, .go_sleep, .go_wake, .slow, .suspend_req,
      .resume_req);
   always #20 clk = ~clk;
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // waits for the slave however long it takes; only the timeout ends it
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk iff avs_waitrequest === 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic w);
      if (w) go_wake <= 1'b1;
      else go_sleep <= 1'b1;
      @(posedge clk);
      go_wake <= 1'b0;
      go_sleep <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic run(input uswc_row_t r, input logic [31:0] wken);
      bus(1'b1, `USWC_OFS_CTRL, {30'h0, r.d});
      bus(1'b1, `USWC_OFS_WKEN, wken);
      if (r.sl) cmd(1'b0);
      chk("suspended_mac", {30'h0, r.sl, !r.sl}, {30'h0, suspended, mac_clk_en});
      net_ev <= uswc_pkg::uswc_net_ev_t'(r.n);
      gpio_in <= r.g;
      repeat (4) @(posedge clk);
      net_ev <= '0;
      gpio_in <= 8'h00;
      seen = 1'b0;
      repeat (12) begin
         @(posedge clk);
         if (remote_wakeup === 1'b1) seen = 1'b1;
      end
      chk("remote_wakeup", {31'h0, r.e}, {31'h0, seen});
      if (r.sl && !seen) cmd(1'b1);
      repeat (4) @(posedge clk);
      chk("mac_clk_en", 32'h0000_0001, {31'h0, mac_clk_en});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("port_phy_lowpwr", 32'h0000_0007, {29'h0, port_phy_lowpwr});
      bus(1'b0, `USWC_OFS_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_0002, q);
      for (int i = 0; i < 10; i++) begin
         slow <= i[0];
         run(rows[i], 32'h0000_FF07);
      end
      run('{1, 0, 4, 0, 0}, 32'h0000_FF03);
      run('{1, 0, 2, 0, 1}, 32'h0000_FF03);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      bus(1'b1, `USWC_OFS_IRQ_MSK, 32'h0000_0010);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      bus(1'b1, `USWC_OFS_STAT, 32'h0000_001F);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      bus(1'b0, `USWC_OFS_STAT, 32'h0000_0000);
      chk("stat", 32'h0000_0000, q);
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, q);
      bus(1'b1, `USWC_OFS_CTRL, 32'h0000_0000);
      bus(1'b0, `USWC_OFS_CTRL, 32'h0000_0000);
      chk("ctrl_set", 32'h0000_0000, q);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("mac_clk_en_rst", 32'h0000_0001, {31'h0, mac_clk_en});
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, `USWC_OFS_CTRL, 32'h0000_0000);
      chk("ctrl_rst", 32'h0000_0002, q);
      port_power_en <= 3'h5;
      repeat (3) @(posedge clk);
      chk("port_phy_lowpwr", 32'h0000_0002, {29'h0, port_phy_lowpwr});
      finish_test();
   end
endmodule // tb

// *** verif/uswc_host_model.sv ***
/*
 upstream host model: issues suspend and resume toward the wakeup control.
 assumes one clk domain; the bench commands go_sleep and go_wake.
*/
`timescale 1ns/1ps
module uswc_host_model (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic remote_wakeup,
   input  wire logic go_sleep,
   input  wire logic go_wake,
   input  wire logic slow,
   output logic      suspend_req,
   output logic      resume_req
);
   logic       [3:0] cnt_ff;
   // a slow host lets the wake request stand several cycles
   wire logic        pend    = remote_wakeup && !resume_req;
   wire logic  [3:0] nxt_cnt = pend ? cnt_ff + 4'h1 : 4'h0;
   wire logic        ack     = pend && cnt_ff == (slow ? 4'h6 : 4'h1);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 4'h0;
         suspend_req <= 1'b0;
         resume_req <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         suspend_req <= go_sleep;
         resume_req <= go_wake | ack;
      end
   end
endmodule // uswc_host_model
